// [codec_pkg.sv]
package codec_pkg;

  // Register values after reset, plus the divisor and counter A fix-up values
  localparam logic [4:0] RST_PRESCALE = 5'h09;
  localparam logic [5:0] RST_TRIM = 6'h01;
  localparam logic [5:0] RST_DIVISOR = 6'h24;
  localparam logic [5:0] DIVISOR_FIX = 6'h24;
  localparam logic [5:0] RST_CONTROL = 6'h39;
  localparam logic [6:0] A_WRAP_ADD = 7'h40;
  localparam logic [5:0] A_MIN_VALID = 6'h02;

  // Field positions inside a received word
  localparam int DAC_LSB = 2;
  localparam int TX_PRE_LSB = 9;
  localparam int RX_PRE_LSB = 2;
  localparam int TX_WIDE_LSB = 9;
  localparam int RX_WIDE_LSB = 2;
  localparam int CTL_LSB = 2;

  // Bit positions inside codec_control (d2 is bit 0)
  localparam int CTL_BANDPASS = 0;
  localparam int CTL_LOOPBACK = 1;
  localparam int CTL_AUX_IN = 2;
  localparam int CTL_SYNC = 3;
  localparam int CTL_GAIN_LO = 4;

  // Serial timing counts
  localparam logic [1:0] SCLK_RISE_PHASE = 2'h1;
  localparam logic [1:0] SCLK_FALL_PHASE = 2'h3;
  localparam logic [1:0] SCLK_TAKE_PHASE = 2'h0;
  localparam logic [4:0] WORD_BITS = 5'h10;
  localparam logic [4:0] BYTE_BITS = 5'h08;
  localparam logic [1:0] GAP_LAST = 2'h3;
  localparam logic [1:0] SGAP_FIRST = 2'h1;

  // Command codes in d1:d0
  typedef enum logic [1:0] {
    CMD_PLAIN = 2'h0,
    CMD_PLUS = 2'h1,
    CMD_MINUS = 2'h2,
    CMD_SECONDARY = 2'h3
  } cmd_t;

  // Secondary word kinds in d1:d0
  localparam logic [1:0] SEC_PRESCALE = 2'h0;
  localparam logic [1:0] SEC_TRIM = 2'h1;
  localparam logic [1:0] SEC_DIVISOR = 2'h2;
  localparam logic [1:0] SEC_CONTROL = 2'h3;

  typedef enum logic [4:0] {
    ST_IDLE = 5'h01,
    ST_XFER = 5'h02,
    ST_GAP = 5'h04,
    ST_END = 5'h08,
    ST_SGAP = 5'h10
  } frame_state_t;

endpackage

// [timer_if.sv]
`timescale 1ns/1ps
`default_nettype none
// Settings into one conversion timer and its events back out
interface timer_if;
  logic [4:0] prescale;
  logic [5:0] trim;
  logic [5:0] divisor;
  logic [1:0] adjust;
  logic conv;
  logic filter_level;
  modport ctrl(output prescale, trim, divisor, adjust, input conv, filter_level);
  modport timer(input prescale, trim, divisor, adjust, output conv, filter_level);
endinterface
`default_nettype wire

// [conv_timer.sv]
`timescale 1ns/1ps
`default_nettype none
module conv_timer
  import codec_pkg::*;
(
  input wire logic clock,
  input wire logic rst,
  timer_if.timer tif
);

  logic [5:0] a_reg;
  logic [5:0] a_next;
  logic [5:0] b_reg;
  logic [5:0] b_next;
  logic half_reg;
  logic half_next;
  logic conv_reg;
  logic conv_next;
  logic [4:0] pre_reg;
  logic [4:0] pre_next;
  logic signed [6:0] sum;
  logic [5:0] load_adj;

  // Adjusted counter A value for the reload that follows a conversion
  always_comb begin
    case (tif.adjust)
      CMD_PLUS: sum = $signed({2'b00, tif.prescale}) + $signed({tif.trim[5], tif.trim});
      CMD_MINUS: sum = $signed({2'b00, tif.prescale}) - $signed({tif.trim[5], tif.trim});
      default: sum = $signed({2'b00, tif.prescale});
    endcase
    if (sum < 0) begin
      sum = sum + $signed(A_WRAP_ADD);
    end
    if (sum[5:0] < A_MIN_VALID) begin
      load_adj = {1'b0, tif.prescale};
    end else begin
      load_adj = sum[5:0];
    end
  end

  // Counter A times half filter periods, counter B whole filter periods
  always_comb begin
    a_next = a_reg - 6'h01;
    b_next = b_reg;
    half_next = half_reg;
    conv_next = 1'b0;
    pre_next = pre_reg;
    if (a_reg <= 6'h01) begin
      half_next = ~half_reg;
      a_next = {1'b0, pre_reg};
      if (half_reg) begin
        if (b_reg <= 6'h01) begin
          conv_next = 1'b1;
          a_next = load_adj;
          b_next = tif.divisor;
          pre_next = tif.prescale;
        end else begin
          b_next = b_reg - 6'h01;
        end
      end
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      a_reg <= {1'b0, RST_PRESCALE};
      b_reg <= RST_DIVISOR;
      half_reg <= 1'b0;
      conv_reg <= 1'b0;
      pre_reg <= RST_PRESCALE;
    end else begin
      a_reg <= a_next;
      b_reg <= b_next;
      half_reg <= half_next;
      conv_reg <= conv_next;
      pre_reg <= pre_next;
    end
  end

  assign tif.conv = conv_reg;
  assign tif.filter_level = half_reg;

endmodule
`default_nettype wire

// [codec_serial_timing_control.sv]
// Operation
// - Byte mode: four-shift-clock high frame-sync pulse between bytes, then high.
// - Word mode: syncs low, one 16-bit word each way, syncs high, end pulses.
// - Shift clock is the master clock divided by four.
// - Filter clock is master clock over twice counter A.
// - Conversion rate is filter clock over counter B; tx paces D/A, rx A/D.
// - A counters reload every half filter period, B counters once per conversion period.
// - B counters reload from their period divisor registers.
// - Counter A loads prescale, prescale minus trim, or prescale plus trim.
// - Synchronous mode derives all timing from the transmit counters.
// - Primary word: d15..d2 to D/A, d1:d0 command, 00 plain reload.
// - Command 01 loads prescale plus trim on next reload.
// - Command 10 loads prescale minus trim on next reload.
// - Command 11: tx sync high four shift clocks, then secondary transfer.
// - Secondary transfer fits between primaries without disturbing D/A timing.
// - Synchronous mode keeps rx frame sync idle during secondary transfers.
// - Secondary 00 loads prescales, MSBs at d13 and d6.
// - Secondary 01 loads signed trims, signs at d14 and d7.
// - Secondary 10 loads period divisors, MSBs at d14 and d7.
// - Secondary 11 writes control: d2 bandpass, d3 loopback, d4 aux inputs.
// - Control d5 selects asynchronous (0) or synchronous (1) sections.
// - Control d6 and d7 are held as gain select bits.
// - Reset: prescales 9, trims 1, divisors 24h, control 111001.
// - Negative counter A sum gets 40h added modulo 64.
// - Divisor register written as 0 or 1 becomes 24h.
`timescale 1ns/1ps
`default_nettype none
module codec_serial_timing_control
  import codec_pkg::*;
(
  input wire logic clock,
  input wire logic rst,
  input wire logic word_byte_sel,
  input wire logic serial_in_line,
  input wire logic [15:0] adc_data,
  output logic shift_clock,
  output logic serial_out_line,
  output logic tx_frame_sync_n,
  output logic rx_frame_sync_n,
  output logic tx_end_of_word_n,
  output logic rx_end_of_word_n,
  output logic tx_filter_clock,
  output logic rx_filter_clock,
  output logic tx_convert,
  output logic rx_convert,
  output logic [13:0] dac_data,
  output logic dac_strobe,
  output logic bandpass_insert,
  output logic loopback_enable,
  output logic aux_input_enable,
  output logic sync_mode,
  output logic [1:0] gain_select
);

  function automatic logic [5:0] fix_divisor(input logic [5:0] v);
    return (v < A_MIN_VALID) ? DIVISOR_FIX : v;
  endfunction

  logic dx_s1, dx_s2, wb_s1, wb_s2;
  logic [4:0] tx_pre_reg, tx_pre_next, rx_pre_reg, rx_pre_next;
  logic [5:0] tx_trim_reg, tx_trim_next, rx_trim_reg, rx_trim_next;
  logic [5:0] tx_div_reg, tx_div_next, rx_div_reg, rx_div_next;
  logic [5:0] ctrl_reg, ctrl_next;
  logic [1:0] adj_tx_reg, adj_tx_next, adj_rx_reg, adj_rx_next;
  logic [13:0] dac_reg, dac_next;
  logic strobe_reg, strobe_next;
  logic [1:0] div_reg, div_next;
  logic sclk_reg, sclk_next;
  frame_state_t state_reg, state_next;
  logic [4:0] bit_reg, bit_next;
  logic [1:0] gap_reg, gap_next;
  logic [15:0] in_reg, in_next, out_reg, out_next;
  logic dout_reg, dout_next;
  logic txfs_reg, txfs_next, rxfs_reg, rxfs_next;
  logic txeod_reg, txeod_next, rxeod_reg, rxeod_next;
  logic rxframe_reg, rxframe_next, second_reg, second_next;
  logic byte_reg, byte_next, start_reg, start_next, rxpend_reg, rxpend_next;
  logic txconv_reg, txconv_next, rxconv_reg, rxconv_next;
  logic txscf_reg, txscf_next, rxscf_reg, rxscf_next;
  logic rise, fall, take, sync_sel, rx_event, rx_syncs;

  timer_if tx_if();
  timer_if rx_if();

  // Timer settings come straight from the divider registers
  assign tx_if.prescale = tx_pre_reg;
  assign tx_if.trim = tx_trim_reg;
  assign tx_if.divisor = tx_div_reg;
  assign tx_if.adjust = adj_tx_reg;
  assign rx_if.prescale = rx_pre_reg;
  assign rx_if.trim = rx_trim_reg;
  assign rx_if.divisor = rx_div_reg;
  assign rx_if.adjust = adj_rx_reg;

  conv_timer tx_timer (.clock(clock), .rst(rst), .tif(tx_if));
  conv_timer rx_timer (.clock(clock), .rst(rst), .tif(rx_if));

  // Pin synchronisers
  always_ff @(posedge clock) begin
    dx_s1 <= serial_in_line;
    dx_s2 <= dx_s1;
    wb_s1 <= word_byte_sel;
    wb_s2 <= wb_s1;
  end

  assign sync_sel = ctrl_reg[CTL_SYNC];
  assign rx_event = sync_sel ? tx_if.conv : rx_if.conv;
  assign rise = (div_reg == SCLK_RISE_PHASE);
  assign fall = (div_reg == SCLK_FALL_PHASE);
  // Input bit taken one clock after the fall, once the synchroniser holds it
  assign take = (div_reg == SCLK_TAKE_PHASE);
  assign rx_syncs = rxframe_reg & ~second_reg;

  // Shift clock, frame sequencing and word decode
  always_comb begin
    tx_pre_next = tx_pre_reg;
    rx_pre_next = rx_pre_reg;
    tx_trim_next = tx_trim_reg;
    rx_trim_next = rx_trim_reg;
    tx_div_next = tx_div_reg;
    rx_div_next = rx_div_reg;
    ctrl_next = ctrl_reg;
    adj_tx_next = adj_tx_reg;
    adj_rx_next = adj_rx_reg;
    dac_next = dac_reg;
    strobe_next = 1'b0;
    div_next = div_reg + 2'h1;
    sclk_next = rise ? 1'b1 : (fall ? 1'b0 : sclk_reg);
    state_next = state_reg;
    bit_next = bit_reg;
    gap_next = gap_reg;
    in_next = in_reg;
    out_next = out_reg;
    dout_next = dout_reg;
    txfs_next = txfs_reg;
    rxfs_next = rxfs_reg;
    txeod_next = txeod_reg;
    rxeod_next = rxeod_reg;
    rxframe_next = rxframe_reg;
    second_next = second_reg;
    byte_next = byte_reg;
    start_next = start_reg;
    rxpend_next = rxpend_reg;
    txconv_next = tx_if.conv;
    rxconv_next = rx_event;
    txscf_next = tx_if.filter_level;
    rxscf_next = sync_sel ? tx_if.filter_level : rx_if.filter_level;
    // An adjust command is used by exactly one reload
    if (tx_if.conv) begin
      adj_tx_next = CMD_PLAIN;
    end
    if (rx_event) begin
      adj_rx_next = CMD_PLAIN;
    end
    if (take && state_reg == ST_XFER) begin
      in_next = {in_reg[14:0], dx_s2};
      bit_next = bit_reg + 5'h01;
    end
    if (rise) begin
      case (state_reg)
        ST_IDLE: begin
          if (start_reg) begin
            start_next = 1'b0;
            rxpend_next = 1'b0;
            rxframe_next = sync_sel | rxpend_reg;
            txfs_next = 1'b0;
            rxfs_next = ~(sync_sel | rxpend_reg);
            dout_next = adc_data[15];
            out_next = {adc_data[14:0], 1'b0};
            bit_next = 5'h00;
            second_next = 1'b0;
            byte_next = ~wb_s2;
            state_next = ST_XFER;
          end
        end
        ST_XFER: begin
          if (bit_reg == WORD_BITS) begin
            txfs_next = 1'b1;
            rxfs_next = 1'b1;
            txeod_next = byte_reg;
            rxeod_next = byte_reg | ~rx_syncs;
            state_next = ST_END;
          end else begin
            dout_next = out_reg[15];
            out_next = {out_reg[14:0], 1'b0};
            if (byte_reg && bit_reg == BYTE_BITS) begin
              txfs_next = 1'b1;
              rxfs_next = 1'b1;
              txeod_next = 1'b0;
              rxeod_next = ~rx_syncs;
              gap_next = 2'h0;
              state_next = ST_GAP;
            end
          end
        end
        ST_GAP: begin
          gap_next = gap_reg + 2'h1;
          if (gap_reg == GAP_LAST) begin
            txfs_next = 1'b0;
            rxfs_next = ~rx_syncs;
            state_next = ST_XFER;
          end
        end
        ST_END: begin
          txeod_next = 1'b1;
          rxeod_next = 1'b1;
          state_next = ST_IDLE;
          if (second_reg) begin
            case (in_reg[1:0])
              SEC_PRESCALE: begin
                tx_pre_next = in_reg[TX_PRE_LSB +: 5];
                rx_pre_next = in_reg[RX_PRE_LSB +: 5];
              end
              SEC_TRIM: begin
                tx_trim_next = in_reg[TX_WIDE_LSB +: 6];
                rx_trim_next = in_reg[RX_WIDE_LSB +: 6];
              end
              SEC_DIVISOR: begin
                tx_div_next = fix_divisor(in_reg[TX_WIDE_LSB +: 6]);
                rx_div_next = fix_divisor(in_reg[RX_WIDE_LSB +: 6]);
              end
              default: begin
                ctrl_next = in_reg[CTL_LSB +: 6];
              end
            endcase
          end else begin
            dac_next = in_reg[15:DAC_LSB];
            strobe_next = 1'b1;
            case (in_reg[1:0])
              CMD_PLUS, CMD_MINUS: begin
                adj_tx_next = in_reg[1:0];
                adj_rx_next = in_reg[1:0];
              end
              CMD_SECONDARY: begin
                adj_tx_next = CMD_PLAIN;
                adj_rx_next = CMD_PLAIN;
                gap_next = SGAP_FIRST;
                state_next = ST_SGAP;
              end
              default: begin
                adj_tx_next = CMD_PLAIN;
                adj_rx_next = CMD_PLAIN;
              end
            endcase
          end
        end
        ST_SGAP: begin
          gap_next = gap_reg + 2'h1;
          if (gap_reg == GAP_LAST) begin
            txfs_next = 1'b0;
            rxframe_next = 1'b0;
            second_next = 1'b1;
            bit_next = 5'h00;
            state_next = ST_XFER;
          end
        end
        default: begin
          state_next = ST_IDLE;
        end
      endcase
    end
    // A conversion arriving as the request is taken is kept
    if (tx_if.conv) begin
      start_next = 1'b1;
    end
    if (rx_event) begin
      rxpend_next = 1'b1;
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      tx_pre_reg <= RST_PRESCALE;
      rx_pre_reg <= RST_PRESCALE;
      tx_trim_reg <= RST_TRIM;
      rx_trim_reg <= RST_TRIM;
      tx_div_reg <= RST_DIVISOR;
      rx_div_reg <= RST_DIVISOR;
      ctrl_reg <= RST_CONTROL;
      adj_tx_reg <= CMD_PLAIN;
      adj_rx_reg <= CMD_PLAIN;
      dac_reg <= 14'h0000;
      strobe_reg <= 1'b0;
      div_reg <= 2'h0;
      sclk_reg <= 1'b0;
      state_reg <= ST_IDLE;
      bit_reg <= 5'h00;
      gap_reg <= 2'h0;
      in_reg <= 16'h0000;
      out_reg <= 16'h0000;
      dout_reg <= 1'b0;
      txfs_reg <= 1'b1;
      rxfs_reg <= 1'b1;
      txeod_reg <= 1'b1;
      rxeod_reg <= 1'b1;
      rxframe_reg <= 1'b0;
      second_reg <= 1'b0;
      byte_reg <= 1'b0;
      start_reg <= 1'b0;
      rxpend_reg <= 1'b0;
      txconv_reg <= 1'b0;
      rxconv_reg <= 1'b0;
      txscf_reg <= 1'b0;
      rxscf_reg <= 1'b0;
    end else begin
      tx_pre_reg <= tx_pre_next;
      rx_pre_reg <= rx_pre_next;
      tx_trim_reg <= tx_trim_next;
      rx_trim_reg <= rx_trim_next;
      tx_div_reg <= tx_div_next;
      rx_div_reg <= rx_div_next;
      ctrl_reg <= ctrl_next;
      adj_tx_reg <= adj_tx_next;
      adj_rx_reg <= adj_rx_next;
      dac_reg <= dac_next;
      strobe_reg <= strobe_next;
      div_reg <= div_next;
      sclk_reg <= sclk_next;
      state_reg <= state_next;
      bit_reg <= bit_next;
      gap_reg <= gap_next;
      in_reg <= in_next;
      out_reg <= out_next;
      dout_reg <= dout_next;
      txfs_reg <= txfs_next;
      rxfs_reg <= rxfs_next;
      txeod_reg <= txeod_next;
      rxeod_reg <= rxeod_next;
      rxframe_reg <= rxframe_next;
      second_reg <= second_next;
      byte_reg <= byte_next;
      start_reg <= start_next;
      rxpend_reg <= rxpend_next;
      txconv_reg <= txconv_next;
      rxconv_reg <= rxconv_next;
      txscf_reg <= txscf_next;
      rxscf_reg <= rxscf_next;
    end
  end

  // Outputs straight from flip-flops
  assign shift_clock = sclk_reg;
  assign serial_out_line = dout_reg;
  assign tx_frame_sync_n = txfs_reg;
  assign rx_frame_sync_n = rxfs_reg;
  assign tx_end_of_word_n = txeod_reg;
  assign rx_end_of_word_n = rxeod_reg;
  assign tx_filter_clock = txscf_reg;
  assign rx_filter_clock = rxscf_reg;
  assign tx_convert = txconv_reg;
  assign rx_convert = rxconv_reg;
  assign dac_data = dac_reg;
  assign dac_strobe = strobe_reg;
  assign bandpass_insert = ctrl_reg[CTL_BANDPASS];
  assign loopback_enable = ctrl_reg[CTL_LOOPBACK];
  assign aux_input_enable = ctrl_reg[CTL_AUX_IN];
  assign sync_mode = ctrl_reg[CTL_SYNC];
  assign gain_select = ctrl_reg[CTL_GAIN_LO +: 2];

endmodule
`default_nettype wire

// [codec_timing_asserts.sv]
`timescale 1ns/1ps
`default_nettype none
module codec_timing_asserts (
  input wire logic clock,
  input wire logic rst,
  input wire logic shift_clock,
  input wire logic tx_frame_sync_n,
  input wire logic rx_frame_sync_n,
  input wire logic tx_end_of_word_n,
  input wire logic tx_filter_clock,
  input wire logic rx_filter_clock,
  input wire logic tx_convert,
  input wire logic rx_convert,
  input wire logic [13:0] dac_data,
  input wire logic dac_strobe,
  input wire logic sync_mode
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);
  logic [6:0] low_reg;
  logic [6:0] low_next;
  // Length of the current low run of the transmit frame sync
  always_comb begin
    low_next = (low_reg == 7'h7F) ? low_reg : low_reg + 7'h01;
    if (rst || tx_frame_sync_n) low_next = 7'h00;
  end
  always_ff @(posedge clock) begin
    low_reg <= low_next;
  end
  // Multi-step shapes of the serial frame
  sequence s_byte_gap;
    $fell(tx_end_of_word_n) ##4 !tx_end_of_word_n;
  endsequence
  sequence s_sync_high8;
    tx_frame_sync_n [*8];
  endsequence
  property p_shift_div;
    $rose(shift_clock) |-> shift_clock [*2] ##1 !shift_clock [*2] ##1 shift_clock;
  endproperty
  a_shift_div: assert property (p_shift_div) else $error("shift clock period wrong");
  property p_eod_at_end;
    $fell(tx_end_of_word_n) |-> $rose(tx_frame_sync_n) ##1 !tx_end_of_word_n [*3];
  endproperty
  a_eod_at_end: assert property (p_eod_at_end) else $error("end of word misplaced");
  property p_byte_gap;
    s_byte_gap |-> s_sync_high8 ##4 tx_frame_sync_n ##1 !tx_frame_sync_n;
  endproperty
  a_byte_gap: assert property (p_byte_gap) else $error("byte gap not four shifts");
  property p_frame_len;
    $rose(tx_frame_sync_n) |-> (low_reg == 7'h40) || (low_reg == 7'h20);
  endproperty
  a_frame_len: assert property (p_frame_len) else $error("frame length wrong");
  property p_tx_gap;
    $rose(tx_frame_sync_n) |-> s_sync_high8 ##1 s_sync_high8;
  endproperty
  a_tx_gap: assert property (p_tx_gap) else $error("frame sync gap too short");
  property p_sec_rx_idle;
    $fell(tx_frame_sync_n) && tx_end_of_word_n && !$past(tx_frame_sync_n, 17) |-> rx_frame_sync_n;
  endproperty
  a_sec_rx_idle: assert property (p_sec_rx_idle) else $error("rx sync in secondary");
  property p_rx_with_tx;
    $fell(rx_frame_sync_n) |-> $fell(tx_frame_sync_n);
  endproperty
  a_rx_with_tx: assert property (p_rx_with_tx) else $error("rx frame without tx");
  property p_sync_copy;
    sync_mode [*3] |-> rx_convert == tx_convert && rx_filter_clock == tx_filter_clock;
  endproperty
  a_sync_copy: assert property (p_sync_copy) else $error("rx timing not tx copy");
  property p_frame_at_conv;
    tx_convert && tx_frame_sync_n |-> ##[1:6] $fell(tx_frame_sync_n);
  endproperty
  a_frame_at_conv: assert property (p_frame_at_conv) else $error("frame late");
  property p_dac_update;
    $changed(dac_data) |-> dac_strobe ##1 !dac_strobe;
  endproperty
  a_dac_update: assert property (p_dac_update) else $error("dac update unstrobed");
endmodule
bind codec_serial_timing_control codec_timing_asserts u_asserts (.clock, .rst, .shift_clock,
  .tx_frame_sync_n, .rx_frame_sync_n, .tx_end_of_word_n, .tx_filter_clock, .rx_filter_clock,
  .tx_convert, .rx_convert, .dac_data, .dac_strobe, .sync_mode);
`default_nettype wire

// [host_port_model.sv]
`timescale 1ns/1ps
`default_nettype none
module host_port_model (
  input wire logic shift_clock,
  input wire logic tx_frame_sync_n,
  input wire logic rx_frame_sync_n,
  input wire logic serial_out_line,
  output logic serial_in_line,
  output logic [15:0] got_word,
  output logic [15:0] sent_cnt,
  output logic [15:0] got_cnt
);
  logic [15:0] words[$];
  logic [15:0] cur = 16'h0000;
  logic [15:0] sh = 16'h0000;
  int tx_n = 0;
  int rx_n = 0;
  initial begin
    serial_in_line = 1'b1;
    got_word = 16'h0000;
    sent_cnt = 16'h0000;
    got_cnt = 16'h0000;
  end
  // Host shifts a word out, MSB first, just after each framed shift-clock rise
  always @(posedge shift_clock) begin
    #1;
    if (tx_frame_sync_n === 1'b0) begin
      if (tx_n == 0) cur = (words.size() > 0) ? words.pop_front() : 16'h0000;
      serial_in_line = cur[15 - tx_n];
      tx_n++;
      if (tx_n == 16) begin
        tx_n = 0;
        sent_cnt++;
      end
    end else begin
      serial_in_line = ~serial_in_line; // Unframed line never shows a stale bit
    end
  end
  // Host takes the device word on falls while the receive sync is low
  always @(negedge shift_clock) begin
    if (rx_frame_sync_n === 1'b0) begin
      sh = {sh[14:0], serial_out_line};
      rx_n++;
      if (rx_n == 16) begin
        rx_n = 0;
        got_word = sh;
        got_cnt++;
      end
    end
  end
endmodule
`default_nettype wire

// [testbench.sv]
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import codec_pkg::*;
  logic clock = 1'b0;
  logic rst = 1'b1;
  logic word_byte_sel = 1'b1;
  logic [15:0] adc_data = 16'h0000;
  logic serial_in_line, shift_clock, serial_out_line, tx_frame_sync_n, rx_frame_sync_n;
  logic tx_end_of_word_n, rx_end_of_word_n, tx_filter_clock, rx_filter_clock;
  logic tx_convert, rx_convert, dac_strobe, bandpass_insert, loopback_enable;
  logic aux_input_enable, sync_mode;
  logic [1:0] gain_select;
  logic [13:0] dac_data;
  logic [15:0] got_word, sent_cnt, got_cnt;
  logic [31:0] seed = 32'h0BC9D248;
  logic [5:0] c;
  logic [13:0] exp_dac[$];
  logic [15:0] exp_adc[$];
  int exp_per[$];
  int errors = 0;
  int checks_done = 0;
  int pa = RST_PRESCALE;
  int tr = RST_TRIM;
  int bd = RST_DIVISOR;
  int pend = 2 * RST_PRESCALE * RST_DIVISOR;
  longint t_conv = 0;
  codec_serial_timing_control u_dut (.clock, .rst, .word_byte_sel, .serial_in_line, .adc_data,
    .shift_clock, .serial_out_line, .tx_frame_sync_n, .rx_frame_sync_n, .tx_end_of_word_n,
    .rx_end_of_word_n, .tx_filter_clock, .rx_filter_clock, .tx_convert, .rx_convert, .dac_data,
    .dac_strobe, .bandpass_insert, .loopback_enable, .aux_input_enable, .sync_mode, .gain_select);
  host_port_model u_host (.shift_clock, .tx_frame_sync_n, .rx_frame_sync_n, .serial_out_line,
    .serial_in_line, .got_word, .sent_cnt, .got_cnt);
  initial begin
    forever #50 clock = ~clock;
  end
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  task automatic check(input logic [15:0] got, input logic [15:0] exp, input string what);
    checks_done++;
    if (got !== exp) begin
      errors++;
      $display("CHECK FAILED %0t %s got %0h expected %0h", $time, what, got, exp);
    end
  endtask
  task automatic wrap_up();
    $display("errors %0d checks_done %0d", errors, checks_done);
    if (errors == 0 && checks_done > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  // One primary frame, plus a secondary word when the command asks for one
  task automatic prim(input logic [1:0] cmd, input logic [15:0] sec);
    logic [15:0] w;
    logic [15:0] n;
    int al;
    @(negedge clock);
    w = 16'(rnd());
    w[1:0] = cmd;
    adc_data = 16'(rnd());
    n = sent_cnt + ((cmd == 2'h3) ? 16'h0002 : 16'h0001);
    exp_dac.push_back(w[15:2]);
    exp_adc.push_back(adc_data);
    u_host.words.push_back(w);
    if (cmd == 2'h3) u_host.words.push_back(sec);
    for (int i = 0; i < 3000 && sent_cnt !== n; i++) @(negedge clock);
    if (sent_cnt !== n) begin
      errors++;
      wrap_up();
    end
    exp_per.push_back(pend);
    if (cmd == 2'h3) begin
      case (sec[1:0])
        2'h0: pa = sec[13:9];
        2'h1: tr = $signed(sec[14:9]);
        2'h2: bd = (sec[14:9] < 6'h02) ? 36 : sec[14:9];
        default: ;
      endcase
    end
    al = (pa + ((cmd == 2'h1) ? tr : (cmd == 2'h2) ? -tr : 0)) & 63;
    if (al < 2) al = pa;
    pend = 2 * pa * bd - pa + al;
  endtask
  // Port results are matched against the oldest note
  always @(posedge clock) begin
    if (dac_strobe === 1'b1) check(16'(dac_data), 16'(exp_dac.pop_front()), "dac");
    if (tx_convert === 1'b1) begin
      if (exp_per.size() > 0) check(16'(($time - t_conv) / 100), 16'(exp_per.pop_front()), "period");
      t_conv = $time;
    end
  end
  // Word received by the host model
  always @(got_cnt) begin
    if (got_cnt !== 16'h0000) check(got_word, exp_adc.pop_front(), "adc word");
  end
  // Main sequence
  initial begin
    repeat (20) @(negedge clock);
    rst = 1'b0;
    check(16'({gain_select, sync_mode, aux_input_enable, loopback_enable, bandpass_insert}), 16'(RST_CONTROL), "reset ctl");
    for (int i = 0; i < 4; i++) prim(2'(i), {8'h00, 6'h39, 2'h3});
    prim(2'h3, {1'b0, 6'h10, 1'b0, 6'h05, 2'h2});
    prim(2'h3, {1'b0, 6'h3D, 1'b0, 6'h02, 2'h1});
    prim(2'h3, {2'h0, 5'h08, 2'h0, 5'h07, 2'h0});
    prim(2'h1, 16'h0000);
    prim(2'h2, 16'h0000);
    prim(2'h3, {1'b0, 6'h34, 1'b0, 6'h3F, 2'h1});
    prim(2'h1, 16'h0000);
    prim(2'h3, {1'b0, 6'h00, 1'b0, 6'h01, 2'h2});
    word_byte_sel = 1'b0;
    for (int i = 0; i < 4; i++) prim(2'(i), {1'b0, 6'h02, 1'b0, 6'h02, 2'h1});
    for (int i = 0; i < 2; i++) begin
      c = 6'(rnd());
      c[3] = (i == 0);
      prim(2'h3, {8'h00, c, 2'h3});
      repeat (12) @(negedge clock);
      check(16'({gain_select, sync_mode, aux_input_enable, loopback_enable, bandpass_insert}), 16'(c), "control");
    end
    check(16'(exp_dac.size() + exp_adc.size()), 16'h0000, "drained");
    wrap_up();
  end
endmodule
`default_nettype wire
